// [pin_sync.sv]
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: each bit is a slow level, not a data word
// Notes: bits are synchronised independently

`timescale 1ns/1ps
`default_nettype none

module pin_sync
    import strap_cfg_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // ==========================================================
    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule

`default_nettype wire

// [reset_strap_config_select.sv]
// Purpose: capture strap pins at master reset release and run start-up load
// Assumes: pin roles arrive from the device-information loader on clk_sys
// Notes: otp and eeprom engines are outside; this block sequences them
//
// Overview of operation
// [RQ1] latch all pins when master reset rises
// [RQ2] pin 9 low SPI, high I2C
// [RQ3] board keeps pin 8 high during reset
// [RQ4] no select pins assigned: use pins 3..0
// [RQ5] undriven default select pins give index 15
// [RQ6] lowest assigned pin is index LSB
// [RQ7] fewer than four pins: zero upper bits
// [RQ8] more than four pins: wider index word
// [RQ9] index ignored when no stored configurations exist
// [RQ10] address pin gives A2, else zero
// [RQ11] several address pins: highest one wins
// [RQ12] A2 strap ignored in SPI mode
// [RQ13] high disable pin blocks eeprom reads
// [RQ14] any disable pin high blocks eeprom
// [RQ15] pin roles from device-information record
// [RQ16] derived settings stay writable afterwards
// [RQ17] defaults: clocks off, pins as inputs
// [RQ18] start-up from straps, otp, eeprom, defaults
// [RQ19] test-access pins should carry no strap role
// [RQ20] select pins carry no other strap role
// [RQ21] bad checksum: skip load, keep defaults
// [RQ22] no eeprom search in SPI mode
// [RQ23] captured straps held until overwritten

`timescale 1ns/1ps
`default_nettype none

module reset_strap_config_select
    import strap_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic master_reset_low,
    input wire logic [GPIO_N-1:0] gpio_pin,
    input wire logic [GPIO_N-1:0] devinfo_sel_mask,
    input wire logic [GPIO_N-1:0] devinfo_addr_mask,
    input wire logic [GPIO_N-1:0] devinfo_eedis_mask,
    input wire logic otp_has_user_cfg,
    output logic otp_load_req,
    output logic [GPIO_N-1:0] otp_load_index,
    input wire logic otp_load_done,
    input wire logic otp_checksum_ok,
    output logic otp_apply,
    output logic eeprom_search_req,
    input wire logic eeprom_search_done,
    input wire logic eeprom_found,
    output logic eeprom_apply,
    input wire logic cfg_stream_done,
    input wire logic cfg_wr_en,
    input wire logic [1:0] cfg_wr_sel,
    input wire logic [GPIO_N-1:0] cfg_wr_data,
    input wire logic host_wr_en,
    input wire logic [1:0] host_wr_sel,
    input wire logic [GPIO_N-1:0] host_wr_data,
    output logic [GPIO_N-1:0] captured_gpio,
    output logic [GPIO_N-1:0] cfg_index,
    output logic [CNT_W-1:0] cfg_index_width,
    output logic serial_is_i2c,
    output logic i2c_addr_a2,
    output logic eeprom_search_en,
    output logic strap_fault,
    output logic [NUM_OUT-1:0] out_clk_en,
    output logic [GPIO_N-1:0] gpio_out_mode,
    output logic boot_done
);

    // ==========================================================
    // helpers

    // packs the masked pins downward, lowest pin into bit 0
    function automatic logic [GPIO_N-1:0] compact_bits(
        input logic [GPIO_N-1:0] mask,
        input logic [GPIO_N-1:0] val
    );
        logic [GPIO_N-1:0] res;
        logic [CNT_W-1:0] pos;
        res = GPIO_ALL_ZERO;
        pos = '0;
        for (int i = 0; i < GPIO_N; i++) begin
            if (mask[i]) begin
                res[pos[CNT_W-2:0]] = val[i];
                pos = pos + CNT_ONE;
            end
        end
        return res;
    endfunction

    function automatic logic [CNT_W-1:0] count_ones(
        input logic [GPIO_N-1:0] mask
    );
        logic [CNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < GPIO_N; i++) begin
            if (mask[i]) begin
                n = n + CNT_ONE;
            end
        end
        return n;
    endfunction

    // later set pins overwrite earlier ones, so the top index wins
    function automatic logic highest_pick(
        input logic [GPIO_N-1:0] mask,
        input logic [GPIO_N-1:0] val
    );
        logic r;
        r = 1'b0;
        for (int i = 0; i < GPIO_N; i++) begin
            if (mask[i]) begin
                r = val[i];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // pin synchronisers
    logic mr_sync;
    logic [GPIO_N-1:0] gpio_sync;
    logic mr_prev_ff;

    pin_sync #(
        .WIDTH(1),
        .RST_VAL(1'b0)
    ) u_mr_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d(master_reset_low),
        .q(mr_sync)
    );

    // same depth as the reset path, so both line up at the edge
    pin_sync #(
        .WIDTH(GPIO_N),
        .RST_VAL(GPIO_ALL_ZERO)
    ) u_gpio_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d(gpio_pin),
        .q(gpio_sync)
    );

    // ==========================================================
    // strap decode
    logic mr_rise;
    logic mr_active;
    logic [GPIO_N-1:0] sel_mask_eff;
    logic [GPIO_N-1:0] nxt_index;
    logic [CNT_W-1:0] nxt_width;
    logic nxt_a2;
    logic nxt_eedis;
    logic nxt_serial;

    assign mr_rise = mr_sync & ~mr_prev_ff;
    assign mr_active = ~mr_sync;
    // role masks come from the device-information record [RQ15]
    assign sel_mask_eff = (devinfo_sel_mask == GPIO_ALL_ZERO) ?
        SEL_DEFAULT_MASK : devinfo_sel_mask; // [RQ4]
    // pull-ups read high, so default pins undriven give 4'hf [RQ5]
    assign nxt_index = compact_bits(sel_mask_eff, gpio_sync); // [RQ6] [RQ7]
    assign nxt_width = count_ones(sel_mask_eff); // [RQ8]
    assign nxt_a2 = highest_pick(devinfo_addr_mask, gpio_sync); // [RQ10] [RQ11]
    assign nxt_eedis = |(devinfo_eedis_mask & gpio_sync); // [RQ13] [RQ14]
    assign nxt_serial = gpio_sync[PIN_SERIAL_SEL]; // [RQ2]

    // ==========================================================
    // captured strap state
    logic [GPIO_N-1:0] captured_ff;
    logic [GPIO_N-1:0] cfg_index_ff;
    logic [CNT_W-1:0] cfg_width_ff;
    logic eedis_ff;
    logic strap_fault_ff;

    // captured values move only on the next master reset edge [RQ23]
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mr_prev_ff <= 1'b0;
            captured_ff <= GPIO_ALL_ZERO;
            cfg_index_ff <= CFG_INDEX_RST;
            cfg_width_ff <= SEL_MIN_W;
            eedis_ff <= 1'b0;
            strap_fault_ff <= 1'b0;
        end else begin
            mr_prev_ff <= mr_sync;
            if (mr_rise) begin
                captured_ff <= gpio_sync; // [RQ1]
                cfg_index_ff <= nxt_index;
                cfg_width_ff <= (nxt_width < SEL_MIN_W) ?
                    SEL_MIN_W : nxt_width; // [RQ7]
                eedis_ff <= nxt_eedis;
                // flags a board whose pin 8 reads low at master reset release
                strap_fault_ff <= ~gpio_sync[PIN_MUST_HIGH]; // [RQ3]
            end
        end
    end

    // ==========================================================
    // boot sequencer
    boot_state_t state_ff;
    boot_state_t nxt_state;
    logic serial_i2c_ff;

    // eeprom lives behind the i2c master, absent in SPI mode [RQ22]
    assign eeprom_search_en = serial_i2c_ff & ~eedis_ff; // [RQ13]

    // straps, then otp, then eeprom over the register defaults [RQ18]
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_HOLD: begin
                if (mr_rise) begin
                    nxt_state = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                // unprogrammed parts never use the index [RQ9]
                nxt_state = otp_has_user_cfg ? ST_OTP_REQ : ST_EE_REQ;
            end
            ST_OTP_REQ: begin
                nxt_state = ST_OTP_WAIT;
            end
            ST_OTP_WAIT: begin
                if (otp_load_done) begin
                    nxt_state = otp_checksum_ok ?
                        ST_OTP_APPLY : ST_EE_REQ; // [RQ21]
                end
            end
            ST_OTP_APPLY: begin
                if (cfg_stream_done) begin
                    nxt_state = ST_EE_REQ;
                end
            end
            ST_EE_REQ: begin
                nxt_state = eeprom_search_en ? ST_EE_WAIT : ST_DONE;
            end
            ST_EE_WAIT: begin
                if (eeprom_search_done) begin
                    nxt_state = eeprom_found ? ST_EE_APPLY : ST_DONE;
                end
            end
            ST_EE_APPLY: begin
                if (cfg_stream_done) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                nxt_state = ST_DONE;
            end
            default: begin
                nxt_state = ST_HOLD;
            end
        endcase
        if (mr_active) begin
            nxt_state = ST_HOLD;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_HOLD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign otp_load_req = (state_ff == ST_OTP_REQ);
    assign otp_apply = (state_ff == ST_OTP_APPLY);
    assign eeprom_search_req = (state_ff == ST_EE_REQ) & eeprom_search_en;
    assign eeprom_apply = (state_ff == ST_EE_APPLY);
    assign boot_done = (state_ff == ST_DONE);

    // ==========================================================
    // writable derived settings
    logic cfg_hit;
    logic wr_any;
    wr_field_t wr_sel;
    logic [GPIO_N-1:0] wr_data;
    logic addr_a2_ff;
    logic [NUM_OUT-1:0] clk_en_ff;
    logic [GPIO_N-1:0] gpio_out_ff;

    // loaded data counts only while a checked image streams in [RQ21]
    assign cfg_hit = cfg_wr_en & (otp_apply | eeprom_apply);
    assign wr_any = (host_wr_en | cfg_hit) & ~mr_active;
    // host access wins a same-cycle clash; it is the later authority
    assign wr_sel = wr_field_t'(host_wr_en ? host_wr_sel : cfg_wr_sel);
    assign wr_data = host_wr_en ? host_wr_data : cfg_wr_data;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            serial_i2c_ff <= SERIAL_I2C_RST;
            addr_a2_ff <= ADDR_A2_RST;
            clk_en_ff <= CLK_EN_RST;
            gpio_out_ff <= GPIO_OUT_RST;
        end else if (mr_active) begin
            // clocks off and all pins inputs until loaded [RQ17]
            clk_en_ff <= CLK_EN_RST;
            gpio_out_ff <= GPIO_OUT_RST;
        end else if (mr_rise) begin
            serial_i2c_ff <= nxt_serial; // [RQ2]
            addr_a2_ff <= nxt_a2; // [RQ10]
        end else if (wr_any) begin
            // strap results remain overwritable [RQ16]
            case (wr_sel)
                FLD_SERIAL: begin
                    serial_i2c_ff <= wr_data[0];
                end
                FLD_ADDR_A2: begin
                    addr_a2_ff <= wr_data[0];
                end
                FLD_CLK_EN: begin
                    clk_en_ff <= wr_data[NUM_OUT-1:0];
                end
                FLD_GPIO_OUT: begin
                    gpio_out_ff <= wr_data;
                end
                default: begin
                    gpio_out_ff <= gpio_out_ff;
                end
            endcase
        end
    end

    // ==========================================================
    // outputs
    assign captured_gpio = captured_ff;
    assign cfg_index = cfg_index_ff;
    assign otp_load_index = cfg_index_ff;
    assign cfg_index_width = cfg_width_ff;
    assign serial_is_i2c = serial_i2c_ff;
    assign i2c_addr_a2 = addr_a2_ff & serial_i2c_ff; // [RQ12]
    assign strap_fault = strap_fault_ff;
    assign out_clk_en = clk_en_ff;
    assign gpio_out_mode = gpio_out_ff;

endmodule

`default_nettype wire

// [reset_strap_config_select_tb_top.sv]
// Purpose: directed bench for the reset strap loader
// Assumes: partner model answers otp and eeprom requests
// Notes: pin 8 kept high during reset except in the fault case
`timescale 1ns/1ps
`default_nettype none

module reset_strap_config_select_tb_top
    import strap_cfg_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic master_reset_low = 1'b0;
    logic otp_has_user_cfg = 1'b1;
    logic host_wr_en = 1'b0;
    logic [1:0] host_wr_sel = 2'h0;
    logic [GPIO_N-1:0] gpio_pin = 16'hffff;
    logic [GPIO_N-1:0] host_wr_data = 16'h0000;
    logic [GPIO_N-1:0] devinfo_sel_mask = 16'h0000;
    logic [GPIO_N-1:0] devinfo_addr_mask = 16'h0000;
    logic [GPIO_N-1:0] devinfo_eedis_mask = 16'h0000;
    logic [3:0] lat = 4'h2;
    logic ck_ok = 1'b1;
    logic found = 1'b1;
    logic [7:0] ld_val = 8'h3c;
    wire logic otp_load_req, otp_apply, eeprom_search_req, eeprom_apply;
    wire logic otp_load_done, otp_checksum_ok, eeprom_search_done;
    wire logic eeprom_found, cfg_stream_done, cfg_wr_en, boot_done;
    wire logic serial_is_i2c, i2c_addr_a2, eeprom_search_en, strap_fault;
    wire logic [1:0] cfg_wr_sel;
    wire logic [GPIO_N-1:0] otp_load_index, cfg_wr_data, captured_gpio;
    wire logic [GPIO_N-1:0] cfg_index, gpio_out_mode;
    wire logic [CNT_W-1:0] cfg_index_width;
    wire logic [NUM_OUT-1:0] out_clk_en;
    int failures = 0;
    int tests_run = 0;
    int n_otp = 0;
    int n_ee = 0;

    reset_strap_config_select dut (.clk_sys, .arst_n, .master_reset_low,
        .gpio_pin, .devinfo_sel_mask, .devinfo_addr_mask,
        .devinfo_eedis_mask, .otp_has_user_cfg, .otp_load_req,
        .otp_load_index, .otp_load_done, .otp_checksum_ok, .otp_apply,
        .eeprom_search_req, .eeprom_search_done, .eeprom_found,
        .eeprom_apply, .cfg_stream_done, .cfg_wr_en, .cfg_wr_sel,
        .cfg_wr_data, .host_wr_en, .host_wr_sel, .host_wr_data,
        .captured_gpio, .cfg_index, .cfg_index_width, .serial_is_i2c,
        .i2c_addr_a2, .eeprom_search_en, .strap_fault, .out_clk_en,
        .gpio_out_mode, .boot_done);
    strap_boot_partner u_partner (.clk_sys, .otp_load_req, .otp_apply,
        .eeprom_search_req, .eeprom_apply, .lat, .ck_ok, .found, .ld_val,
        .otp_load_done, .otp_checksum_ok, .eeprom_search_done,
        .eeprom_found, .cfg_stream_done, .cfg_wr_en, .cfg_wr_sel,
        .cfg_wr_data);

    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        n_otp += (otp_load_req === 1'b1);
        n_ee += (eeprom_search_req === 1'b1);
    end

    // ==========================================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic strap(input logic [15:0] p, sm, am, em);
        master_reset_low = 1'b0;
        gpio_pin = p;
        devinfo_sel_mask = sm;
        devinfo_addr_mask = am;
        devinfo_eedis_mask = em;
        step(4);
        chk(out_clk_en, 16'h0000);
        chk(gpio_out_mode, 16'h0000);
        n_otp = 0;
        n_ee = 0;
        master_reset_low = 1'b1;
        step(5);
    endtask
    task automatic wait_boot();
        int n = 0;
        while (boot_done !== 1'b1 && n < 300) begin
            step(1);
            n++;
        end
        chk(boot_done, 16'h0001);
    endtask
    task automatic hw(input logic [1:0] s, input logic [15:0] d);
        host_wr_en = 1'b1;
        host_wr_sel = s;
        host_wr_data = d;
        step(1);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_default();
        strap(16'hffff, 16'h0000, 16'h0000, 16'h0000);
        chk(captured_gpio, 16'hffff);
        chk(cfg_index, 16'h000f);
        chk(cfg_index_width, 16'h0004);
        chk(serial_is_i2c, 16'h0001);
        chk(i2c_addr_a2, 16'h0000);
        chk(eeprom_search_en, 16'h0001);
        wait_boot();
        chk(out_clk_en, {8'h00, ~ld_val});
        hw(2'h2, 16'h005a);
        chk(out_clk_en, 16'h005a);
        hw(2'h3, 16'ha5a5);
        chk(gpio_out_mode, 16'ha5a5);
        hw(2'h1, 16'h0001);
        chk(i2c_addr_a2, 16'h0001);
        hw(2'h0, 16'h0000);
        chk(i2c_addr_a2, 16'h0000);
        host_wr_en = 1'b0;
        gpio_pin = 16'h0000;
        step(4);
        chk(captured_gpio, 16'hffff);
    endtask
    task automatic t_select();
        logic [15:0] m[3] = '{16'h0164, 16'h1080, 16'h003f};
        logic [15:0] p[3] = '{16'h0324, 16'h1300, 16'h032a};
        logic [15:0] x[3] = '{16'h000b, 16'h0002, 16'h002a};
        logic [15:0] w[3] = '{16'h0004, 16'h0004, 16'h0006};
        for (int i = 0; i < 3; i++) begin
            strap(p[i], m[i], 16'h0000, 16'h0000);
            chk(cfg_index, x[i]);
            chk(cfg_index_width, w[i]);
            wait_boot();
        end
    endtask
    task automatic t_addr();
        logic [15:0] p[3] = '{16'h0380, 16'h0320, 16'h0180};
        logic [15:0] a[3] = '{16'h0001, 16'h0000, 16'h0000};
        logic [15:0] s[3] = '{16'h0001, 16'h0001, 16'h0000};
        for (int i = 0; i < 3; i++) begin
            strap(p[i], 16'h0000, 16'h00a0, 16'h0000);
            chk(i2c_addr_a2, a[i]);
            chk(serial_is_i2c, s[i]);
            chk(eeprom_search_en, s[i]);
            wait_boot();
            chk(n_ee[15:0], s[i]);
        end
    endtask
    task automatic t_eedis();
        logic [15:0] p[3] = '{16'h0b00, 16'h0700, 16'h0300};
        logic [15:0] e[3] = '{16'h0000, 16'h0000, 16'h0001};
        for (int i = 0; i < 3; i++) begin
            strap(p[i], 16'h0000, 16'h0000, 16'h0c00);
            chk(eeprom_search_en, e[i]);
            wait_boot();
            chk(n_ee[15:0], e[i]);
        end
    endtask
    task automatic t_badck();
        ck_ok = 1'b0;
        found = 1'b0;
        strap(16'h030a, 16'h0000, 16'h0000, 16'h0000);
        chk(cfg_index, 16'h000a);
        wait_boot();
        chk(n_otp[15:0], 16'h0001);
        chk(out_clk_en, 16'h0000);
        otp_has_user_cfg = 1'b0;
        strap(16'hffff, 16'h0000, 16'h0000, 16'h0000);
        wait_boot();
        chk(n_otp[15:0], 16'h0000);
        strap(16'hfeff, 16'h0000, 16'h0000, 16'h0000);
        chk(strap_fault, 16'h0001);
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        t_default();
        t_select();
        t_addr();
        t_eedis();
        t_badck();
        results();
    end
    // whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        results();
    end
endmodule

`default_nettype wire

// [strap_boot_partner.sv]
// Purpose: behavioural otp and eeprom engines facing the loader
// Assumes: lat is at least one cycle
// Notes: answers after lat cycles; each image writes out_clk_en
`timescale 1ns/1ps
`default_nettype none

module strap_boot_partner
    import strap_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic otp_load_req,
    input wire logic otp_apply,
    input wire logic eeprom_search_req,
    input wire logic eeprom_apply,
    input wire logic [3:0] lat,
    input wire logic ck_ok,
    input wire logic found,
    input wire logic [7:0] ld_val,
    output logic otp_load_done = 1'b0,
    output logic otp_checksum_ok = 1'b0,
    output logic eeprom_search_done = 1'b0,
    output logic eeprom_found = 1'b0,
    output logic cfg_stream_done = 1'b0,
    output logic cfg_wr_en = 1'b0,
    output logic [1:0] cfg_wr_sel = 2'h2,
    output logic [GPIO_N-1:0] cfg_wr_data = 16'h0000
);
    // no idle edge after a transfer: the loader may raise a one-cycle
    // request in the very cycle that the last answer ends
    always begin
        if (otp_load_req === 1'b1) begin
            repeat (lat) @(posedge clk_sys);
            #1 otp_load_done = 1'b1;
            otp_checksum_ok = ck_ok;
            @(posedge clk_sys);
            #1 otp_load_done = 1'b0;
            otp_checksum_ok = ~ck_ok;
        end else if (eeprom_search_req === 1'b1) begin
            repeat (lat) @(posedge clk_sys);
            #1 eeprom_search_done = 1'b1;
            eeprom_found = found;
            @(posedge clk_sys);
            #1 eeprom_search_done = 1'b0;
            eeprom_found = ~found;
        end else if (otp_apply === 1'b1 || eeprom_apply === 1'b1) begin
            // eeprom image inverts so the two sources tell apart
            cfg_wr_data = {8'h00, eeprom_apply ? ~ld_val : ld_val};
            repeat (lat) @(posedge clk_sys);
            #1 cfg_wr_en = 1'b1;
            @(posedge clk_sys);
            #1 cfg_wr_en = 1'b0;
            cfg_wr_data = ~cfg_wr_data;
            cfg_stream_done = 1'b1;
            @(posedge clk_sys);
            #1 cfg_stream_done = 1'b0;
        end else begin
            @(posedge clk_sys);
            #1;
        end
    end
endmodule

`default_nettype wire

// [strap_cfg_assertions.sv]
// Purpose: concurrent checks on the strap loader ports
// Assumes: one clk_sys domain, reset pin synced in two flops
// Notes: settle windows cover the pin synchroniser delay
`timescale 1ns/1ps
`default_nettype none

module strap_cfg_assertions
    import strap_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic master_reset_low,
    input wire logic otp_load_req,
    input wire logic [GPIO_N-1:0] otp_load_index,
    input wire logic [GPIO_N-1:0] cfg_index,
    input wire logic [GPIO_N-1:0] captured_gpio,
    input wire logic [CNT_W-1:0] cfg_index_width,
    input wire logic serial_is_i2c,
    input wire logic i2c_addr_a2,
    input wire logic eeprom_search_en,
    input wire logic eeprom_search_req,
    input wire logic strap_fault,
    input wire logic [NUM_OUT-1:0] out_clk_en,
    input wire logic host_wr_en,
    input wire logic [1:0] host_wr_sel,
    input wire logic [GPIO_N-1:0] host_wr_data
);
    wire logic [NUM_OUT-1:0] host_byte = host_wr_data[NUM_OUT-1:0];

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // ==========================================================
    // named steps
    // synced state lags the raw pin level, so wait it out
    sequence held_low;
        !master_reset_low [*5];
    endsequence
    sequence settled;
        master_reset_low [*8];
    endsequence
    sequence clk_write;
        host_wr_en && host_wr_sel == 2'h2;
    endsequence

    // ==========================================================
    // checks
    a2_gate_a: assert property (
        i2c_addr_a2 |-> serial_is_i2c) else $error("a2 set in spi mode");
    spi_search_a: assert property (
        eeprom_search_en |-> serial_is_i2c) else $error("search in spi");
    search_gate_a: assert property (
        eeprom_search_req |-> eeprom_search_en) else $error("search req");
    load_index_a: assert property (
        otp_load_req |-> otp_load_index == cfg_index)
        else $error("load index differs");
    index_width_a: assert property (
        cfg_index_width >= SEL_MIN_W) else $error("index width small");
    clocks_off_a: assert property (
        held_low |-> out_clk_en == CLK_EN_RST) else $error("clocks on");
    capture_hold_a: assert property (
        settled |-> $stable(captured_gpio)) else $error("capture moved");
    fault_flag_a: assert property (
        settled |-> strap_fault == !captured_gpio[PIN_MUST_HIGH])
        else $error("fault flag wrong");
    host_write_a: assert property (
        settled ##0 clk_write |=> out_clk_en == $past(host_byte))
        else $error("host write lost");
endmodule

bind reset_strap_config_select strap_cfg_assertions u_chk (
    .clk_sys(clk_sys), .arst_n(arst_n),
    .master_reset_low(master_reset_low), .otp_load_req(otp_load_req),
    .otp_load_index(otp_load_index), .cfg_index(cfg_index),
    .captured_gpio(captured_gpio), .cfg_index_width(cfg_index_width),
    .serial_is_i2c(serial_is_i2c), .i2c_addr_a2(i2c_addr_a2),
    .eeprom_search_en(eeprom_search_en),
    .eeprom_search_req(eeprom_search_req), .strap_fault(strap_fault),
    .out_clk_en(out_clk_en), .host_wr_en(host_wr_en),
    .host_wr_sel(host_wr_sel), .host_wr_data(host_wr_data)
);

`default_nettype wire

// [strap_cfg_pkg.sv]
// Purpose: shared constants and types for the reset strap loader
// Assumes: sixteen general-purpose pins, one system clock
// Notes: all pin positions and the derived settings' reset values live here

package strap_cfg_pkg;

    // ==========================================================
    // pin geometry
    localparam int GPIO_N = 16;
    localparam int CNT_W = 5;
    localparam int NUM_OUT = 8;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // fixed strap pins
    localparam int PIN_SERIAL_SEL = 9;
    localparam int PIN_MUST_HIGH = 8;
    localparam logic [GPIO_N-1:0] SEL_DEFAULT_MASK = 16'h000f;
    localparam logic [GPIO_N-1:0] GPIO_ALL_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] SEL_MIN_W = 5'h04;

    // ==========================================================
    // reset values of the derived settings
    localparam logic SERIAL_I2C_RST = 1'b1;
    localparam logic ADDR_A2_RST = 1'b0;
    localparam logic [NUM_OUT-1:0] CLK_EN_RST = 8'h00;
    localparam logic [GPIO_N-1:0] GPIO_OUT_RST = 16'h0000;
    localparam logic [GPIO_N-1:0] CFG_INDEX_RST = 16'h0000;

    // ==========================================================
    // writable setting fields
    typedef enum logic [1:0] {
        FLD_SERIAL = 2'h0,
        FLD_ADDR_A2 = 2'h1,
        FLD_CLK_EN = 2'h2,
        FLD_GPIO_OUT = 2'h3
    } wr_field_t;

    // ==========================================================
    // boot sequence states
    typedef enum logic [8:0] {
        ST_HOLD = 9'h001,
        ST_CAPTURE = 9'h002,
        ST_OTP_REQ = 9'h004,
        ST_OTP_WAIT = 9'h008,
        ST_OTP_APPLY = 9'h010,
        ST_EE_REQ = 9'h020,
        ST_EE_WAIT = 9'h040,
        ST_EE_APPLY = 9'h080,
        ST_DONE = 9'h100
    } boot_state_t;

endpackage
